// File: core/sample_lane_mapper_regs.vh
// constants for the sample lane mapper
`ifndef SAMPLE_LANE_MAPPER_REGS_VH
`define SAMPLE_LANE_MAPPER_REGS_VH
`define LANE_W        32
`define SAMPLE_W      16
`define VALUE_W       14
`define CTRL_W        2
`define CTRL_LSB      14
`define VALUE_LSB     0
`define SAMPLES_PER_WORD 2
`define OCTETS_PER_FRAME 2
`define DEFAULT_LANES 2
`define MAX_LANES     12
`define SINE_STEPS    32
`define SINE_IDX_W    5
`define CTRL_PATTERN  2'h2
`endif

// File: core/pair_buffer.v
// two-entry skid buffer with valid/ready on both sides
`timescale 1ns/1ps
module pair_buffer #(
    parameter WIDTH = 64
)(
    input  wire             i_clk,
    input  wire             i_rstn,
    input  wire [WIDTH-1:0] i_data,
    input  wire             i_valid,
    output wire             o_ready,
    output wire [WIDTH-1:0] o_data,
    output wire             o_valid,
    input  wire             i_ready
);
    reg [WIDTH-1:0] mem_r [0:1];
    reg             rd_ptr_r;
    reg             wr_ptr_r;
    reg [1:0]       count_r;
    wire            push;
    wire            pop;

    assign o_ready = (count_r != 2'h2);
    assign o_valid = (count_r != 2'h0);
    assign o_data  = mem_r[rd_ptr_r];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    // =====================================================
    // storage and pointers
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mem_r[0] <= {WIDTH{1'b0}};
            mem_r[1] <= {WIDTH{1'b0}};
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                mem_r[wr_ptr_r] <= i_data;
                wr_ptr_r        <= ~wr_ptr_r;
            end
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            if (push && !pop)
                count_r <= count_r + 2'h1;
            else if (pop && !push)
                count_r <= count_r - 2'h1;
        end
    end
endmodule

// File: core/sine_source.v
// per-lane 14-bit sine sequence generator, two samples per clock
`timescale 1ns/1ps
`include "sample_lane_mapper_regs.vh"
module sine_source (
    input  wire                  i_clk,
    input  wire                  i_rstn,
    input  wire                  i_advance,
    output wire [`VALUE_W-1:0]   o_even,
    output wire [`VALUE_W-1:0]   o_odd
);
    reg  [`SINE_IDX_W-1:0] idx_r;
    wire [`SINE_IDX_W-1:0] idx_odd;

    // 32-point signed sine table, amplitude 8191
    function [`VALUE_W-1:0] sine_lut;
        input [`SINE_IDX_W-1:0] k;
        begin
            case (k)
                5'h00: sine_lut = 14'h0000; 5'h01: sine_lut = 14'h063F;
                5'h02: sine_lut = 14'h0C3E; 5'h03: sine_lut = 14'h11C6;
                5'h04: sine_lut = 14'h16A0; 5'h05: sine_lut = 14'h1A9B;
                5'h06: sine_lut = 14'h1D90; 5'h07: sine_lut = 14'h1F62;
                5'h08: sine_lut = 14'h1FFF; 5'h09: sine_lut = 14'h1F62;
                5'h0A: sine_lut = 14'h1D90; 5'h0B: sine_lut = 14'h1A9B;
                5'h0C: sine_lut = 14'h16A0; 5'h0D: sine_lut = 14'h11C6;
                5'h0E: sine_lut = 14'h0C3E; 5'h0F: sine_lut = 14'h063F;
                5'h10: sine_lut = 14'h0000; 5'h11: sine_lut = 14'h39C1;
                5'h12: sine_lut = 14'h33C2; 5'h13: sine_lut = 14'h2E3A;
                5'h14: sine_lut = 14'h2960; 5'h15: sine_lut = 14'h2565;
                5'h16: sine_lut = 14'h2270; 5'h17: sine_lut = 14'h209E;
                5'h18: sine_lut = 14'h2001; 5'h19: sine_lut = 14'h209E;
                5'h1A: sine_lut = 14'h2270; 5'h1B: sine_lut = 14'h2565;
                5'h1C: sine_lut = 14'h2960; 5'h1D: sine_lut = 14'h2E3A;
                5'h1E: sine_lut = 14'h33C2; default: sine_lut = 14'h39C1;
            endcase
        end
    endfunction

    assign idx_odd = idx_r + 5'h01;
    assign o_even  = sine_lut(idx_r);
    assign o_odd   = sine_lut(idx_odd);

    // =====================================================
    // phase advances by two samples each consumed word
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            idx_r <= 5'h00;
        else if (i_advance)
            idx_r <= idx_r + 5'h02;
    end
endmodule

// File: core/sample_lane_mapper.v
// transport mapper: tx packs sine samples onto stream, rx unpacks and checks
`timescale 1ns/1ps
`include "sample_lane_mapper_regs.vh"
module sample_lane_mapper #(
    parameter LANES            = `DEFAULT_LANES,
    parameter OCTETS_PER_FRAME = `OCTETS_PER_FRAME
)(
    input  wire                       i_clk,
    input  wire                       i_rstn,
    input  wire                       i_tx_enable,
    output reg  [LANES*`LANE_W-1:0]   o_tx_tdata,
    output reg                        o_tx_tvalid,
    input  wire                       i_tx_tready,
    input  wire [LANES*`LANE_W-1:0]   i_rx_tdata,
    input  wire                       i_rx_tvalid,
    output reg                        o_rx_tready,
    output reg  [LANES*`SAMPLE_W-1:0] o_rx_even,
    output reg  [LANES*`SAMPLE_W-1:0] o_rx_odd,
    output reg                        o_rx_valid,
    input  wire                       i_rx_ready,
    output reg                        o_rx_pass,
    output reg                        o_rx_error
);
    // =====================================================
    // configuration limits
    localparam OCT_OK = ((OCTETS_PER_FRAME % 2) == 0) && (OCTETS_PER_FRAME >= 2);
    localparam LANE_OK = (LANES >= 1) && (LANES <= `MAX_LANES);
    localparam SW = LANES * `LANE_W;

    wire [SW-1:0] tx_word;
    wire [SW-1:0] txb_data;
    wire          txb_valid;
    wire          txb_in_ready;
    wire [SW-1:0] rxb_data;
    wire          rxb_valid;
    wire          rxb_in_ready;
    wire          rxb_take;
    wire          tx_push;
    wire [LANES-1:0] lane_bad;
    wire [LANES*`VALUE_W-1:0] ref_even;
    wire [LANES*`VALUE_W-1:0] ref_odd;
    reg  [SW-1:0] rx_hold_r;
    reg           rx_hold_valid_r;
    wire          rxh_valid_nxt;
    wire          rxb_full_nxt;

    // generator pushes a word only while buffer has room
    assign tx_push  = i_tx_enable && txb_in_ready && OCT_OK && LANE_OK;
    assign rxb_take = rxb_valid && (!o_rx_valid || i_rx_ready);

    // next-cycle view of hold stage and rx buffer, so a registered ready never drops a word
    assign rxh_valid_nxt = (i_rx_tvalid && o_rx_tready) || (rx_hold_valid_r && !rxb_in_ready);
    assign rxb_full_nxt  = (!rxb_in_ready && !rxb_take) ||
                           (rxb_in_ready && rxb_valid && rx_hold_valid_r && !rxb_take);

    // =====================================================
    // per-lane packing and checking
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1)
        begin : lane
            wire [`VALUE_W-1:0]  tx_even;
            wire [`VALUE_W-1:0]  tx_odd;
            wire [`VALUE_W-1:0]  rx_even;
            wire [`VALUE_W-1:0]  rx_odd;
            wire [`LANE_W-1:0]   rx_w;

            // one converter per lane, all lanes advance together in the same sine phase
            sine_source u_tx_sine (
                .i_clk     (i_clk),
                .i_rstn    (i_rstn),
                .i_advance (tx_push),
                .o_even    (tx_even),
                .o_odd     (tx_odd)
            );

            // expected sequence for the receive checker
            sine_source u_rx_sine (
                .i_clk     (i_clk),
                .i_rstn    (i_rstn),
                .i_advance (rxb_take),
                .o_even    (rx_even),
                .o_odd     (rx_odd)
            );

            // two samples per lane word, earliest in the low half
            assign tx_word[g*`LANE_W +: `LANE_W] =
                {`CTRL_PATTERN, tx_odd, `CTRL_PATTERN, tx_even};
            assign rx_w = rxb_data[g*`LANE_W +: `LANE_W];
            assign ref_even[g*`VALUE_W +: `VALUE_W] = rx_even;
            assign ref_odd[g*`VALUE_W +: `VALUE_W]  = rx_odd;
            assign lane_bad[g] =
                (rx_w[`VALUE_LSB +: `VALUE_W] != rx_even) ||
                (rx_w[`SAMPLE_W + `VALUE_LSB +: `VALUE_W] != rx_odd) ||
                (rx_w[`CTRL_LSB +: `CTRL_W] != `CTRL_PATTERN) ||
                (rx_w[`SAMPLE_W + `CTRL_LSB +: `CTRL_W] != `CTRL_PATTERN);
        end
    endgenerate

    // =====================================================
    // transmit buffer toward the stream port
    pair_buffer #(
        .WIDTH (SW)
    ) u_tx_buf (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_data  (tx_word),
        .i_valid (tx_push),
        .o_ready (txb_in_ready),
        .o_data  (txb_data),
        .o_valid (txb_valid),
        .i_ready (!o_tx_tvalid || i_tx_tready)
    );

    // output stage: registered stream, held until accepted, refilled on accept for one word per clock
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_tx_tdata  <= {SW{1'b0}};
            o_tx_tvalid <= 1'b0;
        end
        else if (!o_tx_tvalid || i_tx_tready)
        begin
            o_tx_tvalid <= txb_valid;
            if (txb_valid)
                o_tx_tdata <= txb_data;
        end
    end

    // =====================================================
    // receive capture stage, registered ready
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rx_hold_r       <= {SW{1'b0}};
            rx_hold_valid_r <= 1'b0;
            o_rx_tready     <= 1'b0;
        end
        else
        begin
            if (i_rx_tvalid && o_rx_tready)
            begin
                rx_hold_r       <= i_rx_tdata;
                rx_hold_valid_r <= 1'b1;
            end
            else if (rxb_in_ready)
                rx_hold_valid_r <= 1'b0;
            // refuse only when a held word could not move on next cycle
            o_rx_tready <= !(rxh_valid_nxt && rxb_full_nxt);
        end
    end

    pair_buffer #(
        .WIDTH (SW)
    ) u_rx_buf (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_data  (rx_hold_r),
        .i_valid (rx_hold_valid_r),
        .o_ready (rxb_in_ready),
        .o_data  (rxb_data),
        .o_valid (rxb_valid),
        .i_ready (rxb_take)
    );

    // =====================================================
    // unpack to samples and compare against expected sine
    integer k;
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rx_even  <= {(LANES*`SAMPLE_W){1'b0}};
            o_rx_odd   <= {(LANES*`SAMPLE_W){1'b0}};
            o_rx_valid <= 1'b0;
            o_rx_pass  <= 1'b0;
            o_rx_error <= 1'b0;
        end
        else
        begin
            if (rxb_take)
            begin
                for (k = 0; k < LANES; k = k + 1)
                begin
                    o_rx_even[k*`SAMPLE_W +: `SAMPLE_W] <= rxb_data[k*`LANE_W +: `SAMPLE_W];
                    o_rx_odd[k*`SAMPLE_W +: `SAMPLE_W]  <= rxb_data[k*`LANE_W + `SAMPLE_W +: `SAMPLE_W];
                end
                o_rx_valid <= 1'b1;
                // pass is sticky-good until any mismatch; error is sticky
                if (|lane_bad)
                begin
                    o_rx_error <= 1'b1;
                    o_rx_pass  <= 1'b0;
                end
                else if (!o_rx_error)
                    o_rx_pass <= 1'b1;
            end
            else if (i_rx_ready)
                o_rx_valid <= 1'b0;
        end
    end
endmodule

// File: dv/sample_lane_mapper_properties.sv
// checker for the sample lane mapper stream and status ports
`timescale 1ns/1ps
`include "sample_lane_mapper_regs.vh"
module sample_lane_mapper_properties #(
    parameter LANES = 2
)(
    input wire logic                       i_clk,
    input wire logic                       i_rstn,
    input wire logic                       i_tx_enable,
    input wire logic [LANES*`LANE_W-1:0]   o_tx_tdata,
    input wire logic                       o_tx_tvalid,
    input wire logic                       i_tx_tready,
    input wire logic                       i_rx_tvalid,
    input wire logic                       o_rx_tready,
    input wire logic [LANES*`SAMPLE_W-1:0] o_rx_even,
    input wire logic [LANES*`SAMPLE_W-1:0] o_rx_odd,
    input wire logic                       o_rx_valid,
    input wire logic                       i_rx_ready,
    input wire logic                       o_rx_pass,
    input wire logic                       o_rx_error
);
    // ============================================================
    // transmit stream
    property p_tx_hold;
        @(posedge i_clk) disable iff (!i_rstn) o_tx_tvalid && !i_tx_tready |=> o_tx_tvalid && $stable(o_tx_tdata);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx word changed before accept");
    property p_tx_steady;
        @(posedge i_clk) disable iff (!i_rstn)
            o_tx_tvalid && i_tx_tready && i_tx_enable && $past(i_tx_enable) |=> o_tx_tvalid;
    endproperty
    a_tx_steady: assert property (p_tx_steady) else $error("tx stream gap while generating");
    property p_tx_start;
        @(posedge i_clk) disable iff (!i_rstn) !o_tx_tvalid && i_tx_enable && i_tx_tready |-> ##[1:3] o_tx_tvalid;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("tx word late");
    property p_tx_ctrl;
        @(posedge i_clk) disable iff (!i_rstn) o_tx_tvalid |-> o_tx_tdata[31:30] == 2'h2 && o_tx_tdata[15:14] == 2'h2;
    endproperty
    a_tx_ctrl: assert property (p_tx_ctrl) else $error("control bits wrong");
    property p_tx_lanes;
        @(posedge i_clk) disable iff (!i_rstn) o_tx_tvalid |-> o_tx_tdata == {LANES{o_tx_tdata[31:0]}};
    endproperty
    a_tx_lanes: assert property (p_tx_lanes) else $error("lanes differ");
    // ============================================================
    // receive stream and status
    property p_rx_hold;
        @(posedge i_clk) disable iff (!i_rstn)
            o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_even) && $stable(o_rx_odd);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx sample changed before accept");
    property p_rx_latency;
        @(posedge i_clk) disable iff (!i_rstn) i_rx_tvalid && o_rx_tready |-> ##[3:12] o_rx_valid;
    endproperty
    a_rx_latency: assert property (p_rx_latency) else $error("rx word not delivered");
    property p_err_sticky;
        @(posedge i_clk) disable iff (!i_rstn) o_rx_error |=> o_rx_error;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag cleared");
    property p_pass_excl;
        @(posedge i_clk) disable iff (!i_rstn) o_rx_error |-> !o_rx_pass;
    endproperty
    a_pass_excl: assert property (p_pass_excl) else $error("pass with error");
endmodule
bind sample_lane_mapper sample_lane_mapper_properties #(.LANES(LANES)) u_props (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_tx_enable(i_tx_enable), .o_tx_tdata(o_tx_tdata), .o_tx_tvalid(o_tx_tvalid), .i_tx_tready(i_tx_tready),
    .i_rx_tvalid(i_rx_tvalid), .o_rx_tready(o_rx_tready), .o_rx_even(o_rx_even), .o_rx_odd(o_rx_odd),
    .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready), .o_rx_pass(o_rx_pass), .o_rx_error(o_rx_error));

// File: dv/link_partner.sv
// loopback model of the link core stream port
`timescale 1ns/1ps
module link_partner #(
    parameter LANES            = 2,
    parameter OCTETS_PER_FRAME = 2,
    parameter FRAMES_PER_MF    = 32
)(
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic [LANES*32-1:0] i_tx_tdata,
    input  wire logic               i_tx_tvalid,
    output logic                    o_tx_tready,
    output logic [LANES*32-1:0]     o_rx_tdata,
    output logic                    o_rx_tvalid,
    input  wire logic               i_rx_tready,
    input  wire logic               i_stall,
    input  wire logic               i_corrupt,
    output logic                    o_sysref
);
    localparam SREF_PERIOD = OCTETS_PER_FRAME * FRAMES_PER_MF;
    logic [LANES*32-1:0] q[$];
    logic [15:0]         sref_cnt;
    // take tx words, replay them on rx; idle rx data toggles each cycle
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            q.delete();
            o_tx_tready <= 1'b0;
            o_rx_tvalid <= 1'b0;
            o_rx_tdata  <= '0;
        end
        else
        begin
            if (i_tx_tvalid && o_tx_tready)
                q.push_back(i_tx_tdata ^ {{(LANES*32-1){1'b0}}, i_corrupt});
            o_tx_tready <= !i_stall && (q.size() < 4);
            if (!o_rx_tvalid || i_rx_tready)
            begin
                o_rx_tvalid <= (q.size() > 0);
                o_rx_tdata  <= (q.size() > 0) ? q.pop_front() : ~o_rx_tdata;
            end
        end
    end
    // sysref made from the core clock, one pulse every four multiframes
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sref_cnt <= '0;
            o_sysref <= 1'b0;
        end
        else
        begin
            o_sysref <= (sref_cnt == 16'h0000);
            sref_cnt <= (sref_cnt == SREF_PERIOD - 1) ? 16'h0000 : sref_cnt + 16'h0001;
        end
    end
endmodule

// File: dv/sample_lane_mapper_tb.sv
// self-checking testbench for the sample lane mapper
`timescale 1ns/1ps
`include "sample_lane_mapper_regs.vh"
module sample_lane_mapper_tb;
    localparam LANES = 3;
    localparam FRAMES_PER_MF = 32;
    logic                sysref;
    int                  sref_gap;
    logic                i_clk, i_rstn, i_tx_enable, i_rx_ready, stall, corrupt;
    logic [LANES*32-1:0] tx_tdata, rx_tdata;
    logic                tx_tvalid, tx_tready, rx_tvalid, rx_tready, rx_valid, rx_pass, rx_error;
    logic [LANES*16-1:0] rx_even, rx_odd;
    logic [13:0]         sv [0:127];
    logic [LANES*32-1:0] rq[$];
    int                  fails, checked, ntx, nrx;
    sample_lane_mapper #(.LANES(LANES)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_tx_enable(i_tx_enable),
        .o_tx_tdata(tx_tdata), .o_tx_tvalid(tx_tvalid), .i_tx_tready(tx_tready), .i_rx_tdata(rx_tdata),
        .i_rx_tvalid(rx_tvalid), .o_rx_tready(rx_tready), .o_rx_even(rx_even), .o_rx_odd(rx_odd),
        .o_rx_valid(rx_valid), .i_rx_ready(i_rx_ready), .o_rx_pass(rx_pass), .o_rx_error(rx_error));
    link_partner #(.LANES(LANES), .FRAMES_PER_MF(FRAMES_PER_MF)) far (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_tx_tdata(tx_tdata), .i_tx_tvalid(tx_tvalid), .o_tx_tready(tx_tready), .o_rx_tdata(rx_tdata),
        .o_rx_tvalid(rx_tvalid), .i_rx_tready(rx_tready), .i_stall(stall), .i_corrupt(corrupt),
        .o_sysref(sysref));
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // ============================================================
    // compare, wait and report
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_rx(input int n);
        int k;
        for (k = 0; k < 4000 && nrx < n; k++)
            @(posedge i_clk);
        @(negedge i_clk);
        if (nrx < n)
        begin
            chk(nrx, n);
            final_report();
        end
    endtask
    // ============================================================
    // monitors: tx word layout, rx unpacking against words sent in
    always @(posedge i_clk)
    begin
        if (tx_tvalid && tx_tready)
        begin
            for (int g = 0; g < LANES; g++)
                chk({tx_tdata[g*32+30+:2], tx_tdata[g*32+14+:2]}, 4'hA);
            if (ntx < 64)
            begin
                sv[2*ntx]   = tx_tdata[13:0];
                sv[2*ntx+1] = tx_tdata[29:16];
            end
            ntx++;
        end
        if (rx_valid && i_rx_ready)
        begin
            for (int g = 0; g < LANES; g++)
                chk({rx_odd[g*16+:16], rx_even[g*16+:16]}, rq[0][g*32+:32]);
            void'(rq.pop_front());
            nrx++;
        end
        if (rx_tvalid && rx_tready)
            rq.push_back(rx_tdata);
        // sysref spacing, restarted by reset
        if (!i_rstn)
            sref_gap = 0;
        else if (sysref)
        begin
            if (sref_gap > 0)
                chk(sref_gap, `OCTETS_PER_FRAME * FRAMES_PER_MF);
            sref_gap = 1;
        end
        else if (sref_gap > 0)
            sref_gap++;
    end
    // ============================================================
    // scenarios
    task automatic t_stream();
        for (int k = 0; k < 4000 && nrx < 40; k++)
        begin
            @(posedge i_clk);
            i_tx_enable <= 1'b1;
            stall       <= (k % 7) < 3;
            i_rx_ready  <= (k % 5) != 0;
        end
        @(posedge i_clk);
        stall      <= 1'b0;
        i_rx_ready <= 1'b1;
        wait_rx(50);
        chk(sv[0], 14'h0000);
        chk(sv[8], 14'h1FFF);
        for (int k = 0; k < 16; k++)
        begin
            chk(sv[k+16], 14'(-sv[k]));
            chk(sv[k+32], sv[k]);
        end
        chk({rx_pass, rx_error}, 2'h2);
        $display("test stream done");
    endtask
    task automatic t_corrupt();
        int n;
        n = ntx;
        @(posedge i_clk);
        corrupt <= 1'b1;
        for (int k = 0; k < 100 && ntx == n; k++)
            @(posedge i_clk);
        corrupt <= 1'b0;
        wait_rx(nrx + 16);
        chk({rx_pass, rx_error}, 2'h1);
        wait_rx(nrx + 8);
        chk({rx_pass, rx_error}, 2'h1);
        $display("test corrupt done");
    endtask
    task automatic t_rerun();
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk({tx_tvalid, rx_valid, rx_pass, rx_error, rx_tready}, 5'h00);
        rq.delete();
        i_rstn <= 1'b1;
        wait_rx(nrx + 8);
        chk({rx_pass, rx_error}, 2'h2);
        $display("test rerun done");
    endtask
    initial
    begin
        {i_rstn, i_tx_enable, i_rx_ready, stall, corrupt} = 5'h00;
        {fails, checked, ntx, nrx} = '0;
        repeat (8) @(posedge i_clk);
        chk({tx_tvalid, rx_valid, rx_pass, rx_error}, 4'h0);
        i_rstn <= 1'b1;
        $display("test reset done");
        t_stream();
        t_corrupt();
        t_rerun();
        final_report();
    end
endmodule
